// file: psseq_consts.vh
/*
 * Constants of the power state sequencer: register offsets, field positions,
 * reset values, SRAM supply level codes and timing counts.
 * Assumes inclusion by bare name from the sequencer design files.
 */
`ifndef PSSEQ_CONSTS_VH
`define PSSEQ_CONSTS_VH

// Register byte offsets on the AHB-Lite slave
`define PSSEQ_OFS_CTRL      8'h00
`define PSSEQ_OFS_WAKE_EN   8'h04
`define PSSEQ_OFS_RET_SEL   8'h08
`define PSSEQ_OFS_BOOT_INFO 8'h0C
`define PSSEQ_OFS_VECTOR    8'h10
`define PSSEQ_OFS_BLK_PWR   8'h14
`define PSSEQ_OFS_STATUS    8'h18
`define PSSEQ_OFS_IRQ_STAT  8'h1C
`define PSSEQ_OFS_IRQ_CLR   8'h20
`define PSSEQ_OFS_IRQ_EN    8'h24

// Control register fields
`define PSSEQ_CTRL_SLEEP    0
`define PSSEQ_CTRL_OFF      1
`define PSSEQ_CTRL_SLOW_RC  2
`define PSSEQ_CTRL_SLOW_XT  3
`define PSSEQ_CTRL_RTC      4

// Wake enable fields
`define PSSEQ_WAKE_IRQ      0
`define PSSEQ_WAKE_EVT      1
`define PSSEQ_WAKE_PIN      2
`define PSSEQ_WAKE_RTC      3

// Interrupt status fields
`define PSSEQ_IRQ_WAKE      0
`define PSSEQ_IRQ_UVLO      1
`define PSSEQ_IRQ_XTAL      2

// Widths and reset values
`define PSSEQ_NUM_SRAM      5
`define PSSEQ_NUM_BLK       3
`define PSSEQ_BOOT_RST      32'h0000_0000
`define PSSEQ_VEC_RST       32'h0000_0000
`define PSSEQ_RET_RST       5'h1F
`define PSSEQ_BLK_RST       3'h1

// SRAM supply level codes
`define PSSEQ_VSRAM_OFF     2'h0
`define PSSEQ_VSRAM_RET     2'h1
`define PSSEQ_VSRAM_FULL    2'h2

// Probe boot alias address
`define PSSEQ_PROBE_ADDR    32'h0000_0000

// Settling time before entering a low-power state
`define PSSEQ_SETTLE_NS     40
`define PSSEQ_CLK_NS        4
`define PSSEQ_SETTLE_CYC    ((`PSSEQ_SETTLE_NS + `PSSEQ_CLK_NS - 1) / `PSSEQ_CLK_NS)

`endif

// file: psseq_sync.v
/*
 * Two-flop synchroniser bank for asynchronous pins.
 * Assumes inputs come from outside the mclk domain; the first stage is read
 * only by the second.
 */
`default_nettype none

module psseq_sync #(
	parameter W = 1
) (
	input  wire         mclk,
	input  wire         resetn,
	input  wire [W-1:0] din,
	output reg  [W-1:0] dout
);

	reg [W-1:0] meta_r;

	////////////////////////////////////////////////////////////////////////
	// Two stages, metastability settles in the first
	always @(posedge mclk) begin
		if (!resetn) begin
			meta_r <= {W{1'b0}};
			dout   <= {W{1'b0}};
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end

endmodule

`default_nettype wire

// file: psseq_top.v
/*
 * Power state sequencer: normal, clock-gate, sleep and off states, with
 * oscillator, bandgap, regulator and SRAM supply gating, wake selection,
 * undervoltage reset hold and boot-on-wake, behind an AHB-Lite slave.
 * Assumes one 250 MHz clock (mclk) that keeps running in this always-on
 * domain, and comparator and pin inputs that are asynchronous to it.
 */
// Contract
// R1: WFI/WFE halts processor clock
// R2: Clock-gate wake resumes clock, no reboot
// R3: Clock-gate wake from enabled irq/events
// R4: Sleep wakes on pin, RTC, reset, UVLO
// R5: Off wakes on pin, reset, UVLO only
// R6: Main RC runs only in normal
// R7: Bandgap on only in normal
// R8: Retention regulator off only in off
// R9: Slow oscillators, RTC selectable in sleep
// R10: SRAM full, retention, or unpowered per state
// R11: Retention selectable per each SRAM block
// R12: Per-block power control in normal
// R13: Mode, remap, vectors kept across low power
// R14: Processor writes registers to request sleep/off
// R15: Wake from sleep/off reboots via ROM
// R16: UVLO reset with hysteresis thresholds
// R17: Probe config boots probe ROM at zero
// R18: Main RC clocks until fast crystal ready
// R19: Latch wake and retention on entry
`include "psseq_consts.vh"
`default_nettype none

module psseq_top (
	input  wire        mclk,
	input  wire        resetn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Processor side
	input  wire        cpu_sleep_req,
	input  wire        cpu_irq,
	input  wire        cpu_event,
	output reg         cpu_clk_en,
	output reg         cpu_boot_rst,
	output reg         cpu_probe_boot,
	output reg  [31:0] boot_alias_addr,
	// Wake and supply monitors (asynchronous)
	input  wire        wake_pin,
	input  wire        rtc_tick,
	input  wire        ext_reset_n,
	input  wire        vdd_above_release_threshold,
	input  wire        vdd_below_entry_threshold,
	input  wire        fast_xtal_osc_ready,
	input  wire        chip_probe_cfg,
	// Analog controls
	output reg         main_rc_osc_en,
	output reg         bandgap_en,
	output reg         retention_regulator_en,
	output reg         slow_rc_osc_en,
	output reg         slow_xtal_osc_en,
	output reg         rtc_en,
	output reg  [9:0]  sram_vsel,
	output reg  [2:0]  blk_pwr_en,
	output reg         sys_clk_sel_xtal,
	output reg         chip_reset,
	output reg         irq
);

	localparam [4:0] ST_NORMAL = 5'b00001;
	localparam [4:0] ST_GATE   = 5'b00010;
	localparam [4:0] ST_ENTER  = 5'b00100;
	localparam [4:0] ST_SLEEP  = 5'b01000;
	localparam [4:0] ST_OFF    = 5'b10000;
	localparam [31:0] SETTLE_W = `PSSEQ_SETTLE_CYC;
	localparam [7:0] SETTLE    = SETTLE_W[7:0];

	////////////////////////////////////////////////////////////////////////
	// Synchronised asynchronous inputs
	wire [6:0] async_s;
	psseq_sync #(.W(7)) u_sync (
		.mclk   (mclk),
		.resetn (resetn),
		.din    ({chip_probe_cfg, fast_xtal_osc_ready, vdd_below_entry_threshold,
		          vdd_above_release_threshold, ext_reset_n, rtc_tick, wake_pin}),
		.dout   (async_s)
	);
	wire pin_s     = async_s[0];
	wire rtc_s     = async_s[1];
	wire xrst_n_s  = async_s[2];
	wire vhi_s     = async_s[3];
	wire vlo_s     = async_s[4];
	wire xtal_s    = async_s[5];
	wire probe_s   = async_s[6];

	reg [4:0]  state_r;
	reg [4:0]  state_nxt;
	reg [4:0]  ctrl_r;
	reg [3:0]  wake_en_r;
	reg [4:0]  ret_sel_r;
	reg [31:0] boot_info_r;
	reg [31:0] vector_r;
	reg [2:0]  blk_r;
	reg [2:0]  irq_stat_r;
	reg [2:0]  irq_en_r;
	reg [3:0]  wake_lat_r;
	reg [4:0]  ret_lat_r;
	reg [4:0]  ctrl_lat_r;
	reg        off_req_r;
	reg [7:0]  settle_r;
	reg        uvlo_r;
	reg        rtc_d_r;
	reg        xtal_d_r;
	reg        ph_valid_r;
	reg        ph_write_r;
	reg [7:0]  ph_addr_r;
	reg [1:0]  strap_cnt_r;

	////////////////////////////////////////////////////////////////////////
	// Undervoltage lockout with hysteresis
	always @(posedge mclk) begin
		if (!resetn)
			uvlo_r <= 1'b1;
		else if (vlo_s)
			uvlo_r <= 1'b1; // [R16]
		else if (vhi_s)
			uvlo_r <= 1'b0; // [R16]
	end

	// Wake conditions per state
	wire rtc_rise  = rtc_s & ~rtc_d_r;
	wire gate_wake = (cpu_irq & wake_lat_r[`PSSEQ_WAKE_IRQ]) |
	                 (cpu_event & wake_lat_r[`PSSEQ_WAKE_EVT]); // [R3]
	wire hard_wake = ~xrst_n_s | uvlo_r;
	wire slp_wake  = (pin_s & wake_lat_r[`PSSEQ_WAKE_PIN]) |
	                 (rtc_rise & wake_lat_r[`PSSEQ_WAKE_RTC]) | hard_wake; // [R4]
	wire off_wake  = (pin_s & wake_lat_r[`PSSEQ_WAKE_PIN]) | hard_wake; // [R5]
	wire low_req   = ctrl_r[`PSSEQ_CTRL_SLEEP] | ctrl_r[`PSSEQ_CTRL_OFF];

	////////////////////////////////////////////////////////////////////////
	// State sequencing
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_NORMAL: begin
				if (low_req)
					state_nxt = ST_ENTER; // [R14]
				else if (cpu_sleep_req)
					state_nxt = ST_GATE; // [R1]
			end
			ST_GATE: begin
				if (gate_wake | hard_wake)
					state_nxt = ST_NORMAL; // [R2]
			end
			ST_ENTER: begin
				if (settle_r == 8'h00)
					state_nxt = off_req_r ? ST_OFF : ST_SLEEP;
			end
			ST_SLEEP: begin
				if (slp_wake)
					state_nxt = ST_NORMAL;
			end
			ST_OFF: begin
				if (off_wake)
					state_nxt = ST_NORMAL;
			end
			default: state_nxt = ST_NORMAL;
		endcase
	end

	// State register, entry latches and settle count
	always @(posedge mclk) begin
		if (!resetn) begin
			state_r    <= ST_NORMAL;
			wake_lat_r <= 4'h0;
			ret_lat_r  <= `PSSEQ_RET_RST;
			ctrl_lat_r <= 5'h00;
			off_req_r  <= 1'b0;
			settle_r   <= 8'h00;
			rtc_d_r    <= 1'b0;
			xtal_d_r   <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			rtc_d_r  <= rtc_s;
			xtal_d_r <= xtal_s;
			if (state_r == ST_NORMAL) begin
				wake_lat_r <= wake_en_r; // [R19]
				ret_lat_r  <= ret_sel_r; // [R19]
				ctrl_lat_r <= ctrl_r;    // [R19]
				off_req_r  <= ctrl_r[`PSSEQ_CTRL_OFF];
				settle_r   <= SETTLE - 8'h01;
			end else if (state_r == ST_ENTER && settle_r != 8'h00)
				settle_r <= settle_r - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-state analog controls and SRAM supplies
	wire in_norm = (state_r == ST_NORMAL) | (state_r == ST_GATE) | (state_r == ST_ENTER);
	wire in_slp  = (state_r == ST_SLEEP);
	integer i;
	reg [9:0] vsel_nxt;
	always @* begin
		vsel_nxt = 10'h000;
		for (i = 0; i < `PSSEQ_NUM_SRAM; i = i + 1) begin
			if (in_norm)
				vsel_nxt[2*i +: 2] = `PSSEQ_VSRAM_FULL; // [R10]
			else if (in_slp && ret_lat_r[i])
				vsel_nxt[2*i +: 2] = `PSSEQ_VSRAM_RET; // [R10] [R11]
			else
				vsel_nxt[2*i +: 2] = `PSSEQ_VSRAM_OFF;
		end
	end

	// Registered outputs to the power switches
	always @(posedge mclk) begin
		if (!resetn) begin
			main_rc_osc_en         <= 1'b1;
			bandgap_en             <= 1'b1;
			retention_regulator_en <= 1'b1;
			slow_rc_osc_en         <= 1'b1;
			slow_xtal_osc_en       <= 1'b1;
			rtc_en                 <= 1'b1;
			sram_vsel              <= 10'h000;
			blk_pwr_en             <= 3'h0;
			cpu_clk_en             <= 1'b1;
			sys_clk_sel_xtal       <= 1'b0;
			chip_reset             <= 1'b1;
			cpu_boot_rst           <= 1'b1;
		end else begin
			main_rc_osc_en         <= in_norm; // [R6]
			bandgap_en             <= in_norm; // [R7]
			retention_regulator_en <= (state_r != ST_OFF); // [R8]
			slow_rc_osc_en   <= in_norm | (in_slp & ctrl_lat_r[`PSSEQ_CTRL_SLOW_RC]); // [R9]
			slow_xtal_osc_en <= in_norm | (in_slp & ctrl_lat_r[`PSSEQ_CTRL_SLOW_XT]); // [R9]
			rtc_en           <= in_norm | (in_slp & ctrl_lat_r[`PSSEQ_CTRL_RTC]); // [R9]
			sram_vsel        <= vsel_nxt;
			blk_pwr_en       <= in_norm ? blk_r : 3'h0; // [R12]
			cpu_clk_en       <= (state_nxt == ST_NORMAL); // [R1] [R2]
			// Crystal only after it reports ready; drop back on entry to sleep or off, and on undervoltage
			sys_clk_sel_xtal <= in_norm & xtal_d_r & ~uvlo_r; // [R18]
			chip_reset       <= uvlo_r | ~xrst_n_s; // [R16]
			// Boot reset pulses while leaving sleep/off, so ROM code runs again
			cpu_boot_rst     <= uvlo_r | ~xrst_n_s |
			                    ((in_slp | state_r == ST_OFF) & state_nxt == ST_NORMAL); // [R15]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Probe boot strap, caught once the synchroniser holds the pin's value
	always @(posedge mclk) begin
		if (!resetn) begin
			strap_cnt_r     <= 2'h0;
			cpu_probe_boot  <= 1'b0;
			boot_alias_addr <= 32'h0000_0000;
		end else if (strap_cnt_r != 2'h3) begin
			strap_cnt_r <= strap_cnt_r + 2'h1;
			// Sync stages clear in reset, so the third edge is the first true sample
			if (strap_cnt_r == 2'h2) begin
				cpu_probe_boot  <= probe_s; // [R17]
				boot_alias_addr <= probe_s ? `PSSEQ_PROBE_ADDR : boot_info_r; // [R17]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states, always OKAY
	wire take = hsel & hready & htrans[1];
	wire wr   = ph_valid_r & ph_write_r;
	always @(posedge mclk) begin
		if (!resetn) begin
			ph_valid_r <= 1'b0;
			ph_write_r <= 1'b0;
			ph_addr_r  <= 8'h00;
		end else if (hready) begin
			ph_valid_r <= take;
			ph_write_r <= hwrite;
			ph_addr_r  <= haddr;
		end
	end

	// Event sources for the sticky status bits
	wire [2:0] irq_set = {xtal_s & ~xtal_d_r, chip_reset == 1'b0 && uvlo_r,
	                      (state_r != ST_NORMAL) & (state_nxt == ST_NORMAL)};

	// Register writes; mode, remap and vectors survive low power
	always @(posedge mclk) begin
		if (!resetn) begin
			ctrl_r      <= 5'h1C;
			wake_en_r   <= 4'h0;
			ret_sel_r   <= `PSSEQ_RET_RST;
			boot_info_r <= `PSSEQ_BOOT_RST;
			vector_r    <= `PSSEQ_VEC_RST;
			blk_r       <= `PSSEQ_BLK_RST;
			irq_stat_r  <= 3'h0;
			irq_en_r    <= 3'h0;
		end else begin
			// Request bits self-clear once the sequence starts
			if (state_r == ST_ENTER)
				ctrl_r[1:0] <= 2'b00;
			else if (wr && ph_addr_r == `PSSEQ_OFS_CTRL)
				ctrl_r <= hwdata[4:0]; // [R14]
			if (wr && ph_addr_r == `PSSEQ_OFS_WAKE_EN)
				wake_en_r <= hwdata[3:0]; // [R3]
			if (wr && ph_addr_r == `PSSEQ_OFS_RET_SEL)
				ret_sel_r <= hwdata[4:0]; // [R11]
			if (wr && ph_addr_r == `PSSEQ_OFS_BOOT_INFO)
				boot_info_r <= hwdata; // [R13]
			if (wr && ph_addr_r == `PSSEQ_OFS_VECTOR)
				vector_r <= hwdata; // [R13]
			if (wr && ph_addr_r == `PSSEQ_OFS_BLK_PWR)
				blk_r <= hwdata[2:0]; // [R12]
			if (wr && ph_addr_r == `PSSEQ_OFS_IRQ_EN)
				irq_en_r <= hwdata[2:0];
			// Set wins over clear in the same cycle
			irq_stat_r <= (irq_stat_r &
			               ~((wr && ph_addr_r == `PSSEQ_OFS_IRQ_CLR) ? hwdata[2:0] : 3'h0))
			              | irq_set;
		end
	end

	// Read data registered, interrupt level, ready and response
	reg [31:0] rd_nxt;
	always @* begin
		case (haddr)
			`PSSEQ_OFS_CTRL:      rd_nxt = {27'h000_0000, ctrl_r};
			`PSSEQ_OFS_WAKE_EN:   rd_nxt = {28'h000_0000, wake_en_r};
			`PSSEQ_OFS_RET_SEL:   rd_nxt = {27'h000_0000, ret_sel_r};
			`PSSEQ_OFS_BOOT_INFO: rd_nxt = boot_info_r;
			`PSSEQ_OFS_VECTOR:    rd_nxt = vector_r;
			`PSSEQ_OFS_BLK_PWR:   rd_nxt = {29'h0000_0000, blk_r};
			`PSSEQ_OFS_STATUS:    rd_nxt = {24'h00_0000, sys_clk_sel_xtal, uvlo_r, cpu_probe_boot,
			                                state_r};
			`PSSEQ_OFS_IRQ_STAT:  rd_nxt = {29'h0000_0000, irq_stat_r};
			`PSSEQ_OFS_IRQ_EN:    rd_nxt = {29'h0000_0000, irq_en_r};
			default:              rd_nxt = 32'h0000_0000;
		endcase
	end

	always @(posedge mclk) begin
		if (!resetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			irq       <= 1'b0;
		end else begin
			if (take && !hwrite)
				hrdata <= rd_nxt;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			irq       <= |(irq_stat_r & irq_en_r);
		end
	end

endmodule

`default_nettype wire

// file: psseq_properties.sv
/* Concurrent checks on the power state sequencer top ports.
   Assumes one clock, mclk, and a synchronous active-low resetn. */
`default_nettype none
module psseq_properties (
	input wire logic       mclk,
	input wire logic       resetn,
	input wire logic       cpu_sleep_req,
	input wire logic       cpu_clk_en,
	input wire logic       cpu_boot_rst,
	input wire logic       wake_pin,
	input wire logic       ext_reset_n,
	input wire logic       vdd_above_release_threshold,
	input wire logic       vdd_below_entry_threshold,
	input wire logic       main_rc_osc_en,
	input wire logic       bandgap_en,
	input wire logic       retention_regulator_en,
	input wire logic [9:0] sram_vsel,
	input wire logic       chip_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	wire full_any;
	// High bit of a supply code marks full voltage
	assign full_any = sram_vsel[1] | sram_vsel[3] | sram_vsel[5] | sram_vsel[7] | sram_vsel[9];
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////
	chk_rc_bandgap: assert property (main_rc_osc_en == bandgap_en)
		else $error("main RC and bandgap enables differ");
	chk_reg_off: assert property (!retention_regulator_en |-> !main_rc_osc_en &&
		sram_vsel == 10'h000) else $error("regulator off outside off state");
	chk_no_full: assert property (!main_rc_osc_en |-> !full_any)
		else $error("SRAM at full supply in low power");
	chk_gate_stop: assert property (cpu_sleep_req && cpu_clk_en && bandgap_en && !chip_reset
		|-> ##[1:2] !cpu_clk_en) else $error("processor clock not stopped");
	chk_boot_pulse: assert property ($rose(cpu_boot_rst) && !chip_reset |=> !cpu_boot_rst)
		else $error("boot reset longer than one cycle");
	chk_wake_boot: assert property ($rose(main_rc_osc_en) |-> cpu_boot_rst ||
		$past(cpu_boot_rst) || $past(cpu_boot_rst, 2)) else $error("wake without boot reset");
	chk_uvlo_in: assert property (vdd_below_entry_threshold [*4] |=> chip_reset)
		else $error("no reset under entry threshold");
	chk_uvlo_hold: assert property ((chip_reset && !vdd_above_release_threshold) [*4]
		|=> chip_reset) else $error("reset released below release threshold");
	// Six quiet cycles cover the pin synchroniser and the output register
	chk_off_stay: assert property ((!wake_pin && ext_reset_n && !vdd_below_entry_threshold)
		[*6] ##0 !retention_regulator_en |=> !retention_regulator_en)
		else $error("off state left without a wake source");
	cov_gate: cover property (cpu_sleep_req ##[1:2] !cpu_clk_en);
	cov_sleep: cover property ($fell(bandgap_en) && retention_regulator_en);
	cov_off: cover property ($fell(retention_regulator_en));
endmodule
bind psseq_top psseq_properties u_props (
	.mclk(mclk), .resetn(resetn), .cpu_sleep_req(cpu_sleep_req), .cpu_clk_en(cpu_clk_en),
	.cpu_boot_rst(cpu_boot_rst), .wake_pin(wake_pin), .ext_reset_n(ext_reset_n),
	.vdd_above_release_threshold(vdd_above_release_threshold),
	.vdd_below_entry_threshold(vdd_below_entry_threshold), .main_rc_osc_en(main_rc_osc_en),
	.bandgap_en(bandgap_en), .retention_regulator_en(retention_regulator_en),
	.sram_vsel(sram_vsel), .chip_reset(chip_reset)
);
`default_nettype wire

// file: psseq_cpu_model.sv
/* Processor core stand-in: halts on a wait command, raises an interrupt
   or event line on command. Assumes one-cycle command pulses. */
`default_nettype none
module psseq_cpu_model (
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic do_wfi,
	input  wire logic do_wake,
	input  wire logic wake_evt,
	input  wire logic cpu_clk_en,
	output var logic  cpu_sleep_req,
	output var logic  cpu_irq,
	output var logic  cpu_event
);
	timeunit 1ns;
	timeprecision 1ps;
	// Wake lines stay pending until the core clock runs again
	always @(posedge mclk) begin
		if (!resetn) begin
			cpu_sleep_req <= 1'b0;
			cpu_irq <= 1'b0;
			cpu_event <= 1'b0;
		end else begin
			if (do_wfi && cpu_clk_en)
				cpu_sleep_req <= 1'b1;
			else if (!cpu_clk_en)
				cpu_sleep_req <= 1'b0;
			if (do_wake) begin
				cpu_irq <= !wake_evt;
				cpu_event <= wake_evt;
			end else if (cpu_clk_en && !cpu_sleep_req) begin
				cpu_irq <= 1'b0;
				cpu_event <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// file: psseq_tb.sv
/* Self-checking bench: register rows, then gate, sleep, interrupt, off,
   undervoltage and probe cases. Assumes design, checker, model compiled. */
`default_nettype none
`include "psseq_consts.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
`define WT(c) begin n = 0; while (!(c)) begin @(negedge mclk); n++; \
	if (n > 400) begin $display("BAD wait"); err_count++; wrap_up(); end end end
`define PS(s, v) begin @(posedge mclk); s <= v; end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct { logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e; } psseq_row_t;
	logic        mclk = 1'b0;
	logic        resetn, hsel, hwrite, cpu_sleep_req, cpu_irq, cpu_event, hreadyout, hresp;
	logic        cpu_clk_en, cpu_boot_rst, cpu_probe_boot, wake_pin, rtc_tick, chip_probe_cfg;
	logic        vdd_above_release_threshold, vdd_below_entry_threshold, fast_xtal_osc_ready;
	logic        main_rc_osc_en, bandgap_en, retention_regulator_en, slow_rc_osc_en, rtc_en;
	logic        slow_xtal_osc_en, sys_clk_sel_xtal, chip_reset, irq, do_wfi, do_wake, wake_evt;
	logic        ext_reset_n;
	logic [1:0]  htrans;
	logic [2:0]  blk_pwr_en;
	logic [7:0]  haddr;
	logic [9:0]  sram_vsel;
	logic [31:0] hwdata, hrdata, boot_alias_addr, q;
	int          err_count, cmp_count, n, i, boot_cnt, b0;
	// Offset, write flag, written value, value read back
	psseq_row_t  rows [8] = '{
		'{`PSSEQ_OFS_CTRL, 1'b0, 32'h0, 32'h0000_001c},
		'{`PSSEQ_OFS_WAKE_EN, 1'b0, 32'h0, 32'h0},
		'{`PSSEQ_OFS_RET_SEL, 1'b0, 32'h0, 32'h0000_001f},
		'{`PSSEQ_OFS_BLK_PWR, 1'b0, 32'h0, 32'h0000_0001},
		'{`PSSEQ_OFS_VECTOR, 1'b1, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
		'{`PSSEQ_OFS_BOOT_INFO, 1'b1, 32'h0000_0003, 32'h0000_0003},
		'{`PSSEQ_OFS_STATUS, 1'b1, 32'hffff_ffff, 32'h0000_0001},
		'{8'h40, 1'b1, 32'hffff_ffff, 32'h0}};
	// 250 MHz clock
	always #2 mclk = ~mclk;
	// Count boot pulses; a one-cycle pulse is easy to miss at a later look
	always @(posedge mclk)
		if (cpu_boot_rst === 1'b1) boot_cnt <= boot_cnt + 1;
	psseq_top dut (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .cpu_sleep_req(cpu_sleep_req), .cpu_irq(cpu_irq),
		.cpu_event(cpu_event), .cpu_clk_en(cpu_clk_en), .cpu_boot_rst(cpu_boot_rst),
		.cpu_probe_boot(cpu_probe_boot), .boot_alias_addr(boot_alias_addr), .wake_pin(wake_pin),
		.rtc_tick(rtc_tick), .ext_reset_n(ext_reset_n),
		.vdd_above_release_threshold(vdd_above_release_threshold),
		.vdd_below_entry_threshold(vdd_below_entry_threshold),
		.fast_xtal_osc_ready(fast_xtal_osc_ready), .chip_probe_cfg(chip_probe_cfg),
		.main_rc_osc_en(main_rc_osc_en), .bandgap_en(bandgap_en),
		.retention_regulator_en(retention_regulator_en), .slow_rc_osc_en(slow_rc_osc_en),
		.slow_xtal_osc_en(slow_xtal_osc_en), .rtc_en(rtc_en), .sram_vsel(sram_vsel),
		.blk_pwr_en(blk_pwr_en), .sys_clk_sel_xtal(sys_clk_sel_xtal), .chip_reset(chip_reset),
		.irq(irq));
	psseq_cpu_model u_cpu (.mclk(mclk), .resetn(resetn), .do_wfi(do_wfi), .do_wake(do_wake),
		.wake_evt(wake_evt), .cpu_clk_en(cpu_clk_en), .cpu_sleep_req(cpu_sleep_req),
		.cpu_irq(cpu_irq), .cpu_event(cpu_event));
	////////////////////////////////////////
	task automatic wrap_up();
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Waits on hready; the slave never stretches, but no count is assumed
	task automatic hwait();
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			$display("BAD hready");
			err_count++;
			wrap_up();
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		hwait();
		htrans <= 2'h0;
		hwdata <= d;
		hwait();
		q = hrdata;
	endtask
	task automatic cpu_cmd(input logic wfi, input logic wk, input logic ev);
		@(posedge mclk);
		do_wfi <= wfi;
		do_wake <= wk;
		wake_evt <= ev;
		@(posedge mclk);
		do_wfi <= 1'b0;
		do_wake <= 1'b0;
	endtask
	////////////////////////////////////////
	initial begin
		{resetn, hsel, hwrite, do_wfi, do_wake, wake_evt, wake_pin, rtc_tick} = 8'h00;
		{vdd_below_entry_threshold, fast_xtal_osc_ready, chip_probe_cfg} = 3'h0;
		{vdd_above_release_threshold, ext_reset_n} = 2'h3;
		htrans = 2'h0;
		haddr = 8'h00;
		hwdata = 32'h0;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		`WT(chip_reset === 1'b0)
		`CHK("vsel", 10'h2aa, sram_vsel)
		`CHK("osc", 4'hf, {main_rc_osc_en, bandgap_en, retention_regulator_en, rtc_en})
		`CHK("blk", 3'h1, blk_pwr_en)
		`CHK("xsel", 1'b0, sys_clk_sel_xtal)
		for (i = 0; i < 8; i++) begin
			if (rows[i].w) bus(rows[i].a, 1'b1, rows[i].d);
			bus(rows[i].a, 1'b0, 32'h0);
			`CHK("reg", {1'b0, rows[i].e}, {hresp, q})
		end
		`PS(fast_xtal_osc_ready, 1'b1)
		`WT(sys_clk_sel_xtal === 1'b1)
		`CHK("xsel", 1'b1, sys_clk_sel_xtal)
		// Clock gate: an event that is not enabled must not wake
		bus(`PSSEQ_OFS_WAKE_EN, 1'b1, 32'h0000_0001);
		b0 = boot_cnt;
		cpu_cmd(1'b1, 1'b0, 1'b0);
		`WT(cpu_clk_en === 1'b0)
		cpu_cmd(1'b0, 1'b1, 1'b1);
		repeat (8) @(negedge mclk);
		`CHK("gate ev", 1'b0, cpu_clk_en)
		cpu_cmd(1'b0, 1'b1, 1'b0);
		`WT(cpu_clk_en === 1'b1)
		`CHK("no boot", 0, boot_cnt - b0)
		// Sleep, with a retention change written during entry
		bus(`PSSEQ_OFS_RET_SEL, 1'b1, 32'h0000_0005);
		bus(`PSSEQ_OFS_WAKE_EN, 1'b1, 32'h0000_0008);
		bus(`PSSEQ_OFS_CTRL, 1'b1, 32'h0000_0019);
		bus(`PSSEQ_OFS_RET_SEL, 1'b1, 32'h0000_001f);
		`WT(main_rc_osc_en === 1'b0)
		@(negedge mclk);
		`CHK("slp vsel", 10'h011, sram_vsel)
		`CHK("slp rails", 2'h1, {bandgap_en, retention_regulator_en})
		`CHK("slp blk", 3'h0, blk_pwr_en)
		`CHK("slp opt", 3'h3, {slow_rc_osc_en, slow_xtal_osc_en, rtc_en})
		b0 = boot_cnt;
		cpu_cmd(1'b0, 1'b1, 1'b0);
		repeat (8) @(negedge mclk);
		`CHK("slp irq", 1'b0, main_rc_osc_en)
		`PS(rtc_tick, 1'b1)
		`WT(main_rc_osc_en === 1'b1)
		`PS(rtc_tick, 1'b0)
		repeat (3) @(negedge mclk);
		`CHK("boot", 1, boot_cnt - b0)
		`CHK("wake vsel", 10'h2aa, sram_vsel)
		// Interrupt: pending wake, masked, enabled, cleared
		bus(`PSSEQ_OFS_IRQ_STAT, 1'b0, 32'h0);
		`CHK("wake st", 1'b1, q[`PSSEQ_IRQ_WAKE])
		`CHK("masked", 1'b0, irq)
		bus(`PSSEQ_OFS_IRQ_EN, 1'b1, 32'h0000_0001);
		repeat (2) @(negedge mclk);
		`CHK("irq on", 1'b1, irq)
		bus(`PSSEQ_OFS_IRQ_CLR, 1'b1, 32'h0000_0007);
		repeat (2) @(negedge mclk);
		`CHK("irq clr", 1'b0, irq)
		// Off: the counter is enabled yet must not wake it
		bus(`PSSEQ_OFS_WAKE_EN, 1'b1, 32'h0000_000c);
		bus(`PSSEQ_OFS_CTRL, 1'b1, 32'h0000_0012);
		`WT(retention_regulator_en === 1'b0)
		@(negedge mclk);
		`CHK("off", 12'h000, {sram_vsel, rtc_en, main_rc_osc_en})
		`PS(rtc_tick, 1'b1)
		repeat (10) @(negedge mclk);
		`CHK("off rtc", 1'b0, retention_regulator_en)
		b0 = boot_cnt;
		`PS(rtc_tick, 1'b0)
		`PS(wake_pin, 1'b1)
		`WT(retention_regulator_en === 1'b1)
		`PS(wake_pin, 1'b0)
		repeat (3) @(negedge mclk);
		`CHK("off boot", 1, boot_cnt - b0)
		// External reset pin wakes sleep with no source enabled
		bus(`PSSEQ_OFS_WAKE_EN, 1'b1, 32'h0000_0000);
		bus(`PSSEQ_OFS_CTRL, 1'b1, 32'h0000_0001);
		`WT(bandgap_en === 1'b0)
		`PS(ext_reset_n, 1'b0)
		`WT(main_rc_osc_en === 1'b1)
		`CHK("xrst wake", 2'h3, {chip_reset, main_rc_osc_en})
		`PS(ext_reset_n, 1'b1)
		`WT(chip_reset === 1'b0)
		// Undervoltage: no entry in the band between thresholds
		`PS(vdd_above_release_threshold, 1'b0)
		repeat (6) @(negedge mclk);
		`CHK("band", 1'b0, chip_reset)
		`PS(vdd_below_entry_threshold, 1'b1)
		`WT(chip_reset === 1'b1)
		repeat (4) @(negedge mclk);
		`PS(vdd_below_entry_threshold, 1'b0)
		repeat (8) @(negedge mclk);
		`CHK("hyst", 1'b1, chip_reset)
		`PS(vdd_above_release_threshold, 1'b1)
		`WT(chip_reset === 1'b0)
		bus(`PSSEQ_OFS_IRQ_STAT, 1'b0, 32'h0);
		`CHK("uvlo st", 1'b1, q[`PSSEQ_IRQ_UVLO])
		// Second reset in the probe configuration
		`PS(resetn, 1'b0)
		chip_probe_cfg <= 1'b1;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		`WT(chip_reset === 1'b0)
		repeat (4) @(negedge mclk);
		`CHK("probe", 33'h1_0000_0000, {cpu_probe_boot, boot_alias_addr})
		wrap_up();
	end
endmodule
`default_nettype wire
